/* design/eec_top.v */
// How it works
// - all counts update together each interval
// - 16-bit violation count at addresses 00/01
// - type 0: count same-polarity successive marks
// - type 0 with hdb3 on: skip substitution word violations
// - type 1: count same-polarity successive violations
// - violations counted even during sync loss
// - violation count sticks at 65535
// - 10-bit crc4 count at 02[1:0], 03
// - crc4/E-bit hold off on FAS/CRC4 loss
// - count each received E bit of zero
// - 10-bit E-bit count at 04[1:0], 05
// - 12-bit count of bad framing words
// - framing count idle during loss of sync
// - framing bits 11:6 at 02, 5:0 at 04
// - interval flag per second or 62.5 ms
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.vh"

module eec_top #(
  parameter [`EEC_TICK_W-1:0] TICK_CYCLES = `EEC_SHORT_INTERVAL_CYC
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // receive line decoder
  input  wire        rx_bit_en,
  input  wire        rx_mark,
  input  wire        rx_mark_neg,
  // receive framer
  input  wire        rx_crc4_err,
  input  wire        rx_ebit_valid,
  input  wire        rx_ebit,
  input  wire        rx_fas_err,
  input  wire        receive_loss_of_sync,
  input  wire        rx_crc4_sync_lost,
  // interval indication
  output reg         interval_timer_flag
);

  // increment shared by all counters, saturating only the 16-bit violation count
  function [15:0] eec_bump;
    input [15:0] val;
    input        en;
    begin
      if (en && (val != `EEC_SAT_MAX))
        eec_bump = val + 16'h0001;
      else
        eec_bump = val;
    end
  endfunction

  // register match for a finished transfer that raised no error
  function eec_hits;
    input [7:0] idx;
    input [7:0] want;
    input       err;
    begin
      eec_hits = (idx == want) && !err;
    end
  endfunction

  // control and timer
  reg  [7:0]             ctrl_r;
  wire                   interval_select_bit;
  wire                   violation_type_bit;
  wire                   receive_hdb3_decode_enable;
  wire                   boundary;

  // line violation tracking
  reg                    have_mark_r;
  reg                    last_pol_r;
  reg  [1:0]             zero_run_r;
  reg                    have_bpv_r;
  reg                    last_bpv_pol_r;
  reg                    bpv;
  reg                    hdb3_word;
  reg                    cv;
  reg                    viol_hit;

  // running counts
  reg  [`EEC_VIOL_W-1:0] viol_run_r;
  reg  [`EEC_CRC_W-1:0]  crc_run_r;
  reg  [`EEC_FEB_W-1:0]  feb_run_r;
  reg  [`EEC_FAS_W-1:0]  fas_run_r;
  reg  [`EEC_VIOL_W-1:0] viol_run_nxt;
  reg  [`EEC_CRC_W-1:0]  crc_run_nxt;
  reg  [`EEC_FEB_W-1:0]  feb_run_nxt;
  reg  [`EEC_FAS_W-1:0]  fas_run_nxt;

  // full-width results of the shared increment
  reg  [15:0]            crc_wide;
  reg  [15:0]            feb_wide;
  reg  [15:0]            fas_wide;

  // snapshots seen by software
  reg  [`EEC_VIOL_W-1:0] viol_snap_r;
  reg  [`EEC_CRC_W-1:0]  crc_snap_r;
  reg  [`EEC_FEB_W-1:0]  feb_snap_r;
  reg  [`EEC_FAS_W-1:0]  fas_snap_r;

  // bus decode
  wire                   setup_ph;
  wire                   access_done;
  wire [7:0]             reg_idx;
  wire                   idx_ok;
  reg  [7:0]             rd_byte;
  reg                    rd_hit;
  wire                   status_read;
  wire                   ctrl_write;
  reg  [7:0]             ctrl_nxt;
  reg                    flag_nxt;
  reg                    pslverr_nxt;
  reg  [31:0]            prdata_nxt;

  assign interval_select_bit        = ctrl_r[`EEC_CTRL_INTERVAL_SEL_BIT];
  assign violation_type_bit         = ctrl_r[`EEC_CTRL_VIOL_TYPE_BIT];
  assign receive_hdb3_decode_enable = ctrl_r[`EEC_CTRL_HDB3_EN_BIT];

  // boundary generator, one second or one sixteenth of it
  eec_interval_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .short_sel  (interval_select_bit),
    .boundary_r (boundary)
  );

  // classify the current received mark
  always @* begin
    bpv       = 1'b0;
    hdb3_word = 1'b0;
    cv        = 1'b0;
    viol_hit  = 1'b0;
    if (rx_bit_en && rx_mark) begin
      // same polarity as the previous mark
      bpv = have_mark_r && (rx_mark_neg == last_pol_r);
      // 000V or B00V: violation after two or three zeros
      hdb3_word = bpv && ((zero_run_r == `EEC_HDB3_RUN_BV) ||
                          (zero_run_r == `EEC_HDB3_RUN_V));
      // violation sharing polarity with the previous violation
      cv = bpv && have_bpv_r && (rx_mark_neg == last_bpv_pol_r);
      if (violation_type_bit)
        viol_hit = cv;
      else
        viol_hit = bpv && !(receive_hdb3_decode_enable && hdb3_word);
    end
  end

  // mark polarity and zero run history
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      have_mark_r    <= 1'b0;
      last_pol_r     <= 1'b0;
      zero_run_r     <= 2'h0;
      have_bpv_r     <= 1'b0;
      last_bpv_pol_r <= 1'b0;
    end else if (rx_bit_en) begin
      if (rx_mark) begin
        have_mark_r <= 1'b1;
        last_pol_r  <= rx_mark_neg;
        zero_run_r  <= 2'h0;
        if (bpv) begin
          have_bpv_r     <= 1'b1;
          last_bpv_pol_r <= rx_mark_neg;
        end
      end else if (zero_run_r != 2'h3) begin
        zero_run_r <= zero_run_r + 2'h1; // stops at three
      end
    end
  end

  // next values of the running counts
  always @* begin
    // violations count regardless of sync state
    viol_run_nxt = eec_bump(viol_run_r, viol_hit);
    // narrower counts ride in the low bits of the shared increment
    crc_wide     = eec_bump({6'h00, crc_run_r}, rx_crc4_err);
    feb_wide     = eec_bump({6'h00, feb_run_r}, rx_ebit_valid && !rx_ebit);
    fas_wide     = eec_bump({4'h0, fas_run_r}, rx_fas_err);
    crc_run_nxt  = crc_run_r;
    feb_run_nxt  = feb_run_r;
    fas_run_nxt  = fas_run_r;
    // crc4 and E bits need both framing and crc4 multiframe lock
    if (!receive_loss_of_sync && !rx_crc4_sync_lost) begin
      crc_run_nxt = crc_wide[`EEC_CRC_W-1:0]; // framer rate stays far below the top
      feb_run_nxt = feb_wide[`EEC_FEB_W-1:0];
    end
    // framing word errors only while in sync
    if (!receive_loss_of_sync) begin
      fas_run_nxt = fas_wide[`EEC_FAS_W-1:0];
    end
  end

  // running counts and interval snapshots
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      viol_run_r  <= {`EEC_VIOL_W{1'b0}};
      crc_run_r   <= {`EEC_CRC_W{1'b0}};
      feb_run_r   <= {`EEC_FEB_W{1'b0}};
      fas_run_r   <= {`EEC_FAS_W{1'b0}};
      viol_snap_r <= {`EEC_VIOL_W{1'b0}};
      crc_snap_r  <= {`EEC_CRC_W{1'b0}};
      feb_snap_r  <= {`EEC_FEB_W{1'b0}};
      fas_snap_r  <= {`EEC_FAS_W{1'b0}};
    end else if (boundary) begin
      // events of the boundary cycle close the old interval
      viol_snap_r <= viol_run_nxt;
      crc_snap_r  <= crc_run_nxt;
      feb_snap_r  <= feb_run_nxt;
      fas_snap_r  <= fas_run_nxt;
      viol_run_r  <= {`EEC_VIOL_W{1'b0}};
      crc_run_r   <= {`EEC_CRC_W{1'b0}};
      feb_run_r   <= {`EEC_FEB_W{1'b0}};
      fas_run_r   <= {`EEC_FAS_W{1'b0}};
    end else begin
      viol_run_r <= viol_run_nxt;
      crc_run_r  <= crc_run_nxt;
      feb_run_r  <= feb_run_nxt;
      fas_run_r  <= fas_run_nxt;
    end
  end

  // apb phase decode, word index from byte address
  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && pready;
  assign reg_idx     = paddr[9:2];
  assign idx_ok      = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000);
  assign status_read = access_done && !pwrite &&
                       eec_hits(reg_idx, `EEC_IDX_STATUS, pslverr);
  assign ctrl_write  = access_done && pwrite &&
                       eec_hits(reg_idx, `EEC_IDX_CTRL, pslverr);

  // read data mux for the mapped registers
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = idx_ok;
    case (reg_idx)
      `EEC_IDX_VIOL_HIGH: begin
        rd_byte = viol_snap_r[15:8];
      end
      `EEC_IDX_VIOL_LOW: begin
        rd_byte = viol_snap_r[7:0];
      end
      `EEC_IDX_CRC_FAS_HIGH: begin
        rd_byte = {fas_snap_r[11:6], crc_snap_r[9:8]};
      end
      `EEC_IDX_CRC_LOW: begin
        rd_byte = crc_snap_r[7:0];
      end
      `EEC_IDX_FEB_FAS_MID: begin
        rd_byte = {fas_snap_r[5:0], feb_snap_r[9:8]};
      end
      `EEC_IDX_FEB_LOW: begin
        rd_byte = feb_snap_r[7:0];
      end
      `EEC_IDX_CTRL: begin
        rd_byte = ctrl_r;
      end
      `EEC_IDX_STATUS: begin
        rd_byte = {3'h0, interval_timer_flag, 4'h0};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // apb answer next values: one cycle after setup, no extra wait
  always @* begin
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h00000000;
    if (setup_ph) begin
      pslverr_nxt = !rd_hit;
      if (rd_hit && !pwrite) begin
        prdata_nxt = {24'h000000, rd_byte};
      end
    end
  end

  // apb answer registers, pready only in the access cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // control next value, spare bits forced to zero
  always @* begin
    ctrl_nxt = ctrl_r;
    if (ctrl_write) begin
      ctrl_nxt = {pwdata[7:6], 3'h0, pwdata[2], 2'h0};
    end
  end

  // control register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `EEC_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // interval flag next value: a boundary beats a read clear
  always @* begin
    flag_nxt = interval_timer_flag;
    if (status_read) begin
      flag_nxt = 1'b0;
    end
    if (boundary) begin
      flag_nxt = 1'b1;
    end
  end

  // interval flag register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interval_timer_flag <= 1'b0;
    end else begin
      interval_timer_flag <= flag_nxt;
    end
  end

endmodule
`default_nettype wire

/* pkg/eec_defines.vh */
`ifndef EEC_DEFINES_VH
`define EEC_DEFINES_VH

// register indices; byte address is four times the index
`define EEC_IDX_VIOL_HIGH    8'h00
`define EEC_IDX_VIOL_LOW     8'h01
`define EEC_IDX_CRC_FAS_HIGH 8'h02
`define EEC_IDX_CRC_LOW      8'h03
`define EEC_IDX_FEB_FAS_MID  8'h04
`define EEC_IDX_FEB_LOW      8'h05
`define EEC_IDX_CTRL         8'h06
`define EEC_IDX_STATUS       8'h07

// control register fields
`define EEC_CTRL_INTERVAL_SEL_BIT 7
`define EEC_CTRL_VIOL_TYPE_BIT    6
`define EEC_CTRL_HDB3_EN_BIT      2
`define EEC_CTRL_RESET            8'h00

// status register fields
`define EEC_STAT_INTERVAL_FLAG_BIT 4

// counter widths and saturation limit
`define EEC_VIOL_W  16
`define EEC_CRC_W   10
`define EEC_FEB_W   10
`define EEC_FAS_W   12
`define EEC_SAT_MAX 16'hFFFF

// zero runs ahead of an hdb3 substitution violation
`define EEC_HDB3_RUN_BV 2'h2
`define EEC_HDB3_RUN_V  2'h3

// interval timing
`define EEC_CLK_HZ             40000000
`define EEC_SHORT_INTERVAL_US  62500
`define EEC_SHORT_INTERVAL_CYC 22'h2625A0
`define EEC_SUBS_PER_SEC       16
`define EEC_SUB_LAST           4'hF
`define EEC_TICK_W             22

`endif

/* design/eec_interval_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.vh"

module eec_interval_timer #(
  parameter [`EEC_TICK_W-1:0] TICK_CYCLES = `EEC_SHORT_INTERVAL_CYC
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rst,
  // interval choice
  input  wire short_sel,
  // boundary pulse
  output reg  boundary_r
);

  reg [`EEC_TICK_W-1:0] cyc_r;
  reg [3:0]             sub_r;
  wire                  tick;

  // end of one short interval
  assign tick = (cyc_r == TICK_CYCLES - 1'b1);

  // short-interval prescaler and sixteenth counter
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_r      <= {`EEC_TICK_W{1'b0}};
      sub_r      <= 4'h0;
      boundary_r <= 1'b0;
    end else begin
      boundary_r <= 1'b0;
      if (tick) begin
        cyc_r <= {`EEC_TICK_W{1'b0}};
        sub_r <= sub_r + 4'h1; // wraps after sixteen ticks, one second
        boundary_r <= short_sel | (sub_r == `EEC_SUB_LAST);
      end else begin
        cyc_r <= cyc_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/eec_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.vh"
module eec_props #(
  parameter [`EEC_TICK_W-1:0] TICK_CYCLES = 22'd20
) (
  // watched ports
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        interval_timer_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] age_r;
  wire rd_st = psel && penable && pready && !pwrite && paddr == 32'h1C;
  wire near = ((age_r + 32'h1) % TICK_CYCLES) < 4;
  // cycles since reset release
  always @(posedge ref_clk or posedge rst) begin
    if (rst) age_r <= 32'h0;
    else age_r <= age_r + 32'h1;
  end
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (psel && !penable && (paddr > 32'h1F || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("bad address accepted");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_ctrl_spare: assert property (pready && !pwrite && paddr == 32'h18
    |-> (prdata[7:0] & 8'h3B) == 8'h0) else $error("spare control bits set");
  chk_flag_period: assert property ($rose(interval_timer_flag) |-> near)
    else $error("flag off the interval grid");
  chk_flag_hold: assert property (interval_timer_flag && !rd_st |=> interval_timer_flag)
    else $error("flag dropped without read");
  chk_flag_clear: assert property (rd_st |=> !interval_timer_flag || near)
    else $error("flag not cleared by read");
  cover property (rd_st && interval_timer_flag);
  cover property (pslverr);
  cover property ($rose(interval_timer_flag));
endmodule
bind eec_top eec_props #(.TICK_CYCLES(TICK_CYCLES)) eec_props_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .interval_timer_flag(interval_timer_flag));
`default_nettype wire

/* tb/eec_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eec_line_model (
  // clock and control
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       run,
  input wire logic [1:0] sync_mode,
  // decoder and framer outputs
  output logic           rx_bit_en,
  output logic           rx_mark,
  output logic           rx_mark_neg,
  output logic           rx_crc4_err,
  output logic           rx_ebit_valid,
  output logic           rx_ebit,
  output logic           rx_fas_err,
  output logic           receive_loss_of_sync,
  output logic           rx_crc4_sync_lost
);
  logic [1:0] zeros_r;
  logic [7:0] rnd;
  // random line bits, framer pulses, sync levels
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {rx_bit_en, rx_mark, rx_mark_neg, rx_crc4_err, rx_ebit_valid} <= 5'h0;
      {rx_ebit, rx_fas_err, receive_loss_of_sync, rx_crc4_sync_lost} <= 4'h0;
      zeros_r <= 2'h0;
    end else begin
      rnd = 8'($urandom);
      rx_bit_en <= run && rnd[0];
      rx_mark <= rnd[1] || zeros_r == 2'h3; // zero runs capped at three
      rx_mark_neg <= rnd[2];
      if (run && rnd[0]) zeros_r <= (rnd[1] || zeros_r == 2'h3) ? 2'h0 : zeros_r + 2'h1;
      rx_crc4_err <= run && rnd[3];
      rx_ebit_valid <= run && rnd[4];
      rx_ebit <= rnd[5];
      rx_fas_err <= run && rnd[6];
      receive_loss_of_sync <= sync_mode == 2'h1;
      rx_crc4_sync_lost <= sync_mode == 2'h2;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.vh"
module tb_top;
  localparam [`EEC_TICK_W-1:0] TICK = 22'd40;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        run = 1'b0;
  logic        clr = 1'b0;
  logic [1:0]  smode = 2'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, flag, bit_en, mark, neg, crc, ebv, eb, fas, los, csl;
  logic [15:0] t_v = 16'h0;
  logic [11:0] t_f = 12'h0;
  logic [9:0]  t_c = 10'h0;
  logic [9:0]  t_e = 10'h0;
  logic        pv_ok = 1'b0, pv_neg = 1'b0, pb_ok = 1'b0, pb_neg = 1'b0;
  logic [1:0]  zr = 2'h0;
  logic [7:0]  ctrl = 8'h0;
  logic [9:0]  cfg [5] = '{10'h080, 10'h184, 10'h2C0, 10'h0C4, 10'h000};
  int          failures = 0;
  int          n_tests = 0;
  eec_top #(.TICK_CYCLES(TICK)) eec_top_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_en(bit_en), .rx_mark(mark), .rx_mark_neg(neg), .rx_crc4_err(crc),
    .rx_ebit_valid(ebv), .rx_ebit(eb), .rx_fas_err(fas), .receive_loss_of_sync(los),
    .rx_crc4_sync_lost(csl), .interval_timer_flag(flag));
  eec_line_model eec_line_model_i (
    .ref_clk(ref_clk), .rst(rst), .run(run), .sync_mode(smode), .rx_bit_en(bit_en),
    .rx_mark(mark), .rx_mark_neg(neg), .rx_crc4_err(crc), .rx_ebit_valid(ebv), .rx_ebit(eb),
    .rx_fas_err(fas), .receive_loss_of_sync(los), .rx_crc4_sync_lost(csl));
  // clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // expected running counts
  always @(posedge ref_clk) begin
    logic bpv;
    if (bit_en && mark) begin
      bpv = pv_ok && neg == pv_neg;
      if (ctrl[6] ? bpv && pb_ok && neg == pb_neg : bpv && !(ctrl[2] && zr >= 2'h2))
        t_v <= (t_v == 16'hFFFF) ? t_v : t_v + 16'h1;
      if (bpv) {pb_ok, pb_neg} <= {1'b1, neg};
      {pv_ok, pv_neg, zr} <= {2'b10 | {1'b0, neg}, 2'h0};
    end else if (bit_en && zr != 2'h3) zr <= zr + 2'h1;
    if (!csl && !los) begin
      t_c <= t_c + {9'h0, crc};
      t_e <= t_e + {9'h0, ebv && !eb};
    end
    if (!los) t_f <= t_f + {11'h0, fas};
    if (clr) {t_v, t_f, t_c, t_e} <= 48'h0;
  end
  function automatic logic [31:0] exp_reg(input int r);
    case (r)
      0: return {24'h0, t_v[15:8]};
      1: return {24'h0, t_v[7:0]};
      2: return {24'h0, t_f[11:6], t_c[9:8]};
      3: return {24'h0, t_c[7:0]};
      4: return {24'h0, t_f[5:0], t_e[9:8]};
      default: return {24'h0, t_e[7:0]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 8'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic wait_flag;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (flag !== 1'b1 && k < 2000);
    if (flag !== 1'b1) failures++;
  endtask
  task automatic results;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    results;
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    void'($urandom(32));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(4 * i, 32'h0, 1'b0);
    rdc(32'h20, 32'h0, 1'b1);
    rdc(32'h06, 32'h0, 1'b1);
    apb(1'b1, 32'h0, 8'hFF, q, e);
    rdc(32'h0, 32'h0, 1'b0);
    apb(1'b1, 32'h18, 8'hFF, q, e);
    rdc(32'h18, 32'hC4, 1'b0);
    foreach (cfg[i]) begin
      apb(1'b1, 32'h18, cfg[i][7:0], q, e);
      ctrl <= cfg[i][7:0] & 8'hC4;
      smode <= cfg[i][9:8];
      n = cfg[i][7] ? 10 + $urandom % 15 : 600;
      for (int j = 0; j < 2; j++) begin
        apb(1'b0, 32'h1C, 8'h0, q, e);
        wait_flag;
        rdc(32'h1C, 32'h10, 1'b0);
        @(posedge ref_clk);
        chk({31'h0, flag}, 32'h0);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        run <= (j == 0);
        repeat (n) @(posedge ref_clk);
        run <= 1'b0;
        wait_flag;
        for (int r = 0; r < 6; r++) rdc(4 * r, exp_reg(r), 1'b0);
      end
    end
    results;
  end
endmodule
`default_nettype wire
